// ### core/ocdd_top.v
// fetch sequencer, row walker and output fifo of the on-screen character display
// Overview of operation
// - characters land anywhere in a 19 column by 14 row grid
// - eight colours per character, red green blue set by control words
// - only three control words per display row take effect
// - rounding, rimming and reverse video selectable per character
// - 120 patterns stored, one screen uses 64 from the first bank or 56 from the second
// - four sizes each way; vertical per row, horizontal per character
// - cells are 10 by 15 dots and abut with no gap
// - patterns sit in program memory; unused area stays program storage
// - character codes are ordinary data memory the cpu reaches freely
// - fetch mode repeats five stolen cycles then one cpu cycle
// - the cpu is held idle during the five stolen cycles
// - stolen cycles address memories from pattern and character pointers
// - with fetch enabled, a fetch request beats any interrupt request
// - fetch disabled refuses requests; clearing ends fetch after that instruction
// - display enable, bit 0 of 31H, starts and stops the display
// - one 8-bit character word takes an even and the next odd nibble
// - character memory is two banks of 112 nibbles
// - word top two bits are type, low six bits payload
// - types: 00 pattern, 10 control, 01 return bank one, 11 return bank two
// - pattern payload gives pattern address bits 9 to 4; the bank bit comes from 30H
// - return payload: row in upper three, column upper bits lower three
// - return ends the row; two returns in succession end the screen
`timescale 1ns/1ps
`include "ocdd_regs.vh"

module ocdd_fifo #(
	parameter W = 25,
	parameter D = 32,
	parameter AW = 5
) (
	input wire clk,
	input wire rst,
	input wire in_valid,
	output wire in_ready,
	input wire [W-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [W-1:0] out_data
);
	localparam [AW:0] FULL = D[AW:0];
	reg [W-1:0] mem [0:D-1];
	reg [AW-1:0] wr_reg, rd_reg;
	reg [AW:0] cnt_reg;
	wire push, pop;
	// honest flags straight from the occupancy count
	assign in_ready = (cnt_reg != FULL);
	assign out_valid = (cnt_reg != {(AW+1){1'b0}});
	assign out_data = mem[rd_reg];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	// storage has no reset; only pointers and count need a defined value
	always @(posedge clk) begin
		if (push) begin
			mem[wr_reg] <= in_data;
		end
	end

	// pointers wrap naturally since depth is a power of two
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_reg <= {AW{1'b0}};
			rd_reg <= {AW{1'b0}};
			cnt_reg <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_reg <= wr_reg + 1'b1;
			end
			if (pop) begin
				rd_reg <= rd_reg + 1'b1;
			end
			if (push & ~pop) begin
				cnt_reg <= cnt_reg + 1'b1;
			end else if (pop & ~push) begin
				cnt_reg <= cnt_reg - 1'b1;
			end
		end
	end
endmodule // ocdd_fifo

module ocdd_top (
	input wire CLK,
	input wire RST,
	input wire RF_WE,
	input wire [6:0] RF_ADDR,
	input wire [3:0] RF_WDATA,
	output reg [3:0] RF_RDATA,
	input wire [11:0] PC_ADDR,
	input wire [1:0] CPU_DBANK,
	input wire [6:0] CPU_DADDR,
	output wire [11:0] PMEM_ADDR,
	input wire [15:0] PMEM_RDATA,
	output wire [1:0] DMEM_BANK,
	output wire [6:0] DMEM_ADDR,
	input wire [3:0] DMEM_RDATA,
	output wire CPU_HOLD,
	input wire INT_REQ,
	output wire INT_TAKE,
	input wire HSYNC_PULSE,
	input wire VSYNC_N,
	output wire DISPLAY_ON,
	output wire PIX_VALID,
	input wire PIX_READY,
	output wire [24:0] PIX_DATA
);
	localparam ST_IDLE = 3'b001;
	localparam ST_STEAL = 3'b010;
	localparam ST_CPU = 3'b100;
	reg [2:0] state_reg, slot_reg, rgb_reg, style_reg;
	reg fme_reg, den_reg, pbank_reg, have_pat_reg, bank_reg, row_bank_reg, ret_bank_reg;
	reg ret_seen_reg, line_done_reg, scr_done_reg;
	reg [3:0] hi_reg, row_reg, line_reg;
	reg [5:0] pat_reg;
	reg [6:0] ptr_reg, row_start_reg, ret_addr_reg;
	reg [1:0] rep_reg, ctrl_cnt_reg, hsize_reg, vsize_reg, vsize_next_row_reg;
	reg [4:0] col_reg;
	wire fme_next, fifo_ready, req, accept, steal, push, last_line;
	wire [7:0] word;
	wire [1:0] word_id;
	wire [5:0] payload;
	wire [6:0] ptr_inc;
	wire [11:0] pat_addr;
	// flags as the register file sees them; write in the cpu slot takes effect at its edge
	assign fme_next = (RF_WE && RF_ADDR == `OCDD_RF_FME) ? RF_WDATA[`OCDD_FME_BIT] : fme_reg;
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			fme_reg <= 1'b0;
			den_reg <= 1'b0;
			pbank_reg <= 1'b0;
			RF_RDATA <= 4'h0;
		end else begin
			fme_reg <= fme_next;
			if (RF_WE && RF_ADDR == `OCDD_RF_DEN) begin
				den_reg <= RF_WDATA[`OCDD_DEN_BIT];
			end
			if (RF_WE && RF_ADDR == `OCDD_RF_PBANK) begin
				pbank_reg <= RF_WDATA[`OCDD_PBANK_BIT];
			end
			// read back lags the address by one cycle; other bits read zero
			case (RF_ADDR)
				`OCDD_RF_FME: RF_RDATA <= {2'h0, fme_reg, 1'b0};
				`OCDD_RF_PBANK: RF_RDATA <= {3'h0, pbank_reg};
				`OCDD_RF_DEN: RF_RDATA <= {3'h0, den_reg};
				default: RF_RDATA <= 4'h0;
			endcase
		end
	end
	// a group only starts with fifo room, so its single push never overflows
	assign req = den_reg & VSYNC_N & ~scr_done_reg & ~line_done_reg & fifo_ready;
	assign accept = (state_reg == ST_IDLE && fme_reg && req) ||
		(state_reg == ST_CPU && fme_next && req);
	assign steal = (state_reg == ST_STEAL);
	assign CPU_HOLD = steal;
	assign INT_TAKE = INT_REQ & ~steal & ~accept;
	assign DISPLAY_ON = den_reg;
	// five stolen cycles, then one cpu cycle, repeating while requests stand
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			state_reg <= ST_IDLE;
			slot_reg <= 3'h0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					slot_reg <= 3'h0;
					if (accept) begin
						state_reg <= ST_STEAL;
					end
				end
				ST_STEAL: begin
					if (slot_reg == `OCDD_STEAL_LAST) begin
						state_reg <= ST_CPU;
						slot_reg <= 3'h0;
					end else begin
						slot_reg <= slot_reg + 3'h1;
					end
				end
				ST_CPU: begin
					// the clearing write lands here, so fetch ends as that instruction completes
					state_reg <= accept ? ST_STEAL : ST_IDLE;
				end
				default: begin
					state_reg <= ST_IDLE;
					slot_reg <= 3'h0;
				end
			endcase
		end
	end

	// memory address muxes: pointers own the buses only in stolen cycles
	assign pat_addr = {1'b1, pbank_reg, pat_reg, line_reg};
	assign PMEM_ADDR = steal ? pat_addr : PC_ADDR;
	assign DMEM_BANK = steal ? (bank_reg ? `OCDD_DM_BANK2 : `OCDD_DM_BANK1) : CPU_DBANK;
	assign DMEM_ADDR = steal ? {ptr_reg[6:1], slot_reg == `OCDD_SLOT_LO} : CPU_DADDR;
	assign word = {hi_reg, DMEM_RDATA};
	assign word_id = word[7:6];
	assign payload = word[5:0];
	assign ptr_inc = (ptr_reg + 7'h2 >= `OCDD_BANK_NIB) ? 7'h0 : ptr_reg + 7'h2;
	assign last_line = (line_reg == `OCDD_LAST_LINE) && (rep_reg == vsize_reg);
	assign push = steal && slot_reg == `OCDD_SLOT_PAT && have_pat_reg;
	// row walker: vertical sync beats line sync, which beats the fetch datapath
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			hi_reg <= 4'h0;
			pat_reg <= 6'h0;
			have_pat_reg <= 1'b0;
			ptr_reg <= 7'h0;
			bank_reg <= 1'b0;
			row_start_reg <= 7'h0;
			row_bank_reg <= 1'b0;
			ret_addr_reg <= 7'h0;
			ret_bank_reg <= 1'b0;
			ret_seen_reg <= 1'b0;
			line_done_reg <= 1'b0;
			scr_done_reg <= 1'b0;
			row_reg <= 4'h0;
			line_reg <= 4'h0;
			rep_reg <= 2'h0;
			col_reg <= 5'h0;
			ctrl_cnt_reg <= 2'h0;
			rgb_reg <= 3'h7;
			style_reg <= 3'h0;
			hsize_reg <= 2'h0;
			vsize_reg <= 2'h0;
			vsize_next_row_reg <= 2'h0;
		end else if (!VSYNC_N) begin
			// flyback: rewind to the first word of bank one
			ptr_reg <= 7'h0;
			bank_reg <= 1'b0;
			row_start_reg <= 7'h0;
			row_bank_reg <= 1'b0;
			ret_seen_reg <= 1'b0;
			line_done_reg <= 1'b0;
			scr_done_reg <= 1'b0;
			row_reg <= 4'h0;
			line_reg <= 4'h0;
			rep_reg <= 2'h0;
			col_reg <= 5'h0;
			ctrl_cnt_reg <= 2'h0;
			have_pat_reg <= 1'b0;
			vsize_reg <= vsize_next_row_reg;
		end else if (HSYNC_PULSE) begin
			line_done_reg <= 1'b0;
			col_reg <= 5'h0;
			ctrl_cnt_reg <= 2'h0;
			have_pat_reg <= 1'b0;
			if (last_line) begin
				// next row starts where the return word pointed
				line_reg <= 4'h0;
				rep_reg <= 2'h0;
				row_reg <= row_reg + 4'h1;
				ptr_reg <= ret_addr_reg;
				bank_reg <= ret_bank_reg;
				row_start_reg <= ret_addr_reg;
				row_bank_reg <= ret_bank_reg;
				vsize_reg <= vsize_next_row_reg;
				if (row_reg + 4'h1 >= `OCDD_ROWS) begin
					scr_done_reg <= 1'b1;
				end
			end else begin
				// each vertical size step repeats a pattern line
				if (rep_reg == vsize_reg) begin
					rep_reg <= 2'h0;
					line_reg <= line_reg + 4'h1;
				end else begin
					rep_reg <= rep_reg + 2'h1;
				end
				ptr_reg <= row_start_reg;
				bank_reg <= row_bank_reg;
			end
		end else if (steal) begin
			if (slot_reg == `OCDD_SLOT_HI) begin
				hi_reg <= DMEM_RDATA;
			end
			if (slot_reg == `OCDD_SLOT_LO) begin
				case (word_id)
					`OCDD_ID_PAT: begin
						pat_reg <= payload;
						// beyond column 19 or past the second bank's patterns nothing shows
						have_pat_reg <= (col_reg < `OCDD_COLS) &&
							!(pbank_reg && payload >= `OCDD_PAT_LIMIT);
						ptr_reg <= ptr_inc;
						ret_seen_reg <= 1'b0;
					end
					`OCDD_ID_CTRL: begin
						if (ctrl_cnt_reg < `OCDD_MAX_CTRL) begin
							ctrl_cnt_reg <= ctrl_cnt_reg + 2'h1;
							case (payload[5:4])
								`OCDD_CSEL_RGB: rgb_reg <= payload[2:0];
								`OCDD_CSEL_STYLE: style_reg <= payload[2:0];
								`OCDD_CSEL_HSIZE: hsize_reg <= payload[1:0];
								`OCDD_CSEL_VSIZE: vsize_next_row_reg <= payload[1:0];
								default: rgb_reg <= rgb_reg;
							endcase
						end
						ptr_reg <= ptr_inc;
						ret_seen_reg <= 1'b0;
					end
					default: begin
						// a return word: the row ends, or the screen after two in a row
						line_done_reg <= 1'b1;
						ret_seen_reg <= 1'b1;
						if (ret_seen_reg) begin
							scr_done_reg <= 1'b1;
						end
						ret_addr_reg <= {payload[5:3], payload[2:0], 1'b0};
						ret_bank_reg <= (word_id == `OCDD_ID_RET2);
					end
				endcase
			end
			if (push) begin
				have_pat_reg <= 1'b0;
				col_reg <= col_reg + 5'h1;
			end
		end
	end

	// one cell line per entry; dot shifting happens downstream
	ocdd_fifo #(
		.W(`OCDD_FIFO_W),
		.D(`OCDD_FIFO_D),
		.AW(`OCDD_FIFO_AW)
	) u_fifo (
		.clk(CLK),
		.rst(RST),
		.in_valid(push),
		.in_ready(fifo_ready),
		.in_data({vsize_reg, hsize_reg, style_reg, rgb_reg, col_reg, PMEM_RDATA[9:0]}),
		.out_valid(PIX_VALID),
		.out_ready(PIX_READY),
		.out_data(PIX_DATA)
	);
endmodule // ocdd_top

// ### inc/ocdd_regs.vh
// constants for the on-screen character display fetch unit
`ifndef OCDD_REGS_VH
`define OCDD_REGS_VH
`define OCDD_RF_FME 7'h00
`define OCDD_RF_PBANK 7'h30
`define OCDD_RF_DEN 7'h31
`define OCDD_FME_BIT 1
`define OCDD_PBANK_BIT 0
`define OCDD_DEN_BIT 0
`define OCDD_STEAL_LAST 3'h4
`define OCDD_SLOT_HI 3'h0
`define OCDD_SLOT_LO 3'h1
`define OCDD_SLOT_PAT 3'h2
`define OCDD_COLS 5'h13
`define OCDD_ROWS 4'hE
`define OCDD_LAST_LINE 4'hE
`define OCDD_MAX_CTRL 2'h3
`define OCDD_BANK_NIB 7'h70
`define OCDD_PAT_LIMIT 6'h38
`define OCDD_ID_PAT 2'h0
`define OCDD_ID_RET1 2'h1
`define OCDD_ID_CTRL 2'h2
`define OCDD_ID_RET2 2'h3
`define OCDD_CSEL_RGB 2'h0
`define OCDD_CSEL_STYLE 2'h1
`define OCDD_CSEL_HSIZE 2'h2
`define OCDD_CSEL_VSIZE 2'h3
`define OCDD_DM_BANK1 2'h1
`define OCDD_DM_BANK2 2'h2
`define OCDD_FIFO_W 25
`define OCDD_FIFO_D 32
`define OCDD_FIFO_AW 5
`endif

// ### test/ocdd_mem_model.sv
// behavioural program and data memory beside the fetch unit
`timescale 1ns/1ps
module ocdd_mem_model (
	input wire [1:0] dmem_bank,
	input wire [6:0] dmem_addr,
	output wire [3:0] dmem_rdata,
	input wire [11:0] pmem_addr,
	output wire [15:0] pmem_rdata
);
	reg [7:0] word_sel;
	// fixed row, never written while shown: pattern 05h, rgb control 3, pattern 0Ah, return
	always @* begin
		case (dmem_addr[6:1])
			6'h00: word_sel = 8'h05;
			6'h01: word_sel = 8'h83;
			6'h02: word_sel = 8'h0A;
			default: word_sel = 8'h40;
		endcase
	end
	// even nibble carries the high half; both banks answer alike to keep it small
	assign dmem_rdata = dmem_addr[0] ? word_sel[3:0] : word_sel[7:4];
	// dots echo the pattern address so every fetch can be traced
	assign pmem_rdata = {6'h00, pmem_addr[9:0]};
endmodule // ocdd_mem_model

// ### test/ocdd_top_properties.sv
// port checker for the display fetch unit
`timescale 1ns/1ps
module ocdd_props (
	input wire CLK,
	input wire RST,
	input wire RF_WE,
	input wire [6:0] RF_ADDR,
	input wire [3:0] RF_WDATA,
	input wire [3:0] RF_RDATA,
	input wire [11:0] PC_ADDR,
	input wire [11:0] PMEM_ADDR,
	input wire [1:0] CPU_DBANK,
	input wire [6:0] CPU_DADDR,
	input wire [1:0] DMEM_BANK,
	input wire [6:0] DMEM_ADDR,
	input wire CPU_HOLD,
	input wire INT_TAKE,
	input wire DISPLAY_ON,
	input wire PIX_VALID,
	input wire PIX_READY,
	input wire [24:0] PIX_DATA
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	// group shape: exactly five stolen cycles, then at least one cpu cycle
	property p_group;
		$rose(CPU_HOLD) |-> CPU_HOLD [*5] ##1 !CPU_HOLD;
	endproperty
	a_group: assert property (p_group) else $error("stolen run not five");
	property p_pc;
		!CPU_HOLD |-> PMEM_ADDR == PC_ADDR;
	endproperty
	a_pc: assert property (p_pc) else $error("cpu cycle lost program address");
	property p_dmem_cpu;
		!CPU_HOLD |-> DMEM_BANK == CPU_DBANK && DMEM_ADDR == CPU_DADDR;
	endproperty
	a_dmem_cpu: assert property (p_dmem_cpu) else $error("cpu cycle lost data address");
	property p_dmem_bank;
		CPU_HOLD |-> DMEM_BANK == 2'h1 || DMEM_BANK == 2'h2;
	endproperty
	a_dmem_bank: assert property (p_dmem_bank) else $error("fetch outside character banks");
	property p_pat_area;
		CPU_HOLD |-> PMEM_ADDR[11];
	endproperty
	a_pat_area: assert property (p_pat_area) else $error("fetch outside pattern area");
	property p_quiet;
		CPU_HOLD |-> !INT_TAKE;
	endproperty
	a_quiet: assert property (p_quiet) else $error("interrupt taken while stalled");
	property p_prio;
		INT_TAKE |=> !CPU_HOLD;
	endproperty
	a_prio: assert property (p_prio) else $error("interrupt beat a fetch");
	property p_den_on;
		$rose(CPU_HOLD) |-> $past(DISPLAY_ON);
	endproperty
	a_den_on: assert property (p_den_on) else $error("fetch with display off");
	property p_den_wr;
		RF_WE && RF_ADDR == 7'h31 |=> DISPLAY_ON == $past(RF_WDATA[0]);
	endproperty
	a_den_wr: assert property (p_den_wr) else $error("display flag not written");
	property p_fme_rd;
		$past(RF_ADDR) == 7'h00 |-> RF_RDATA[3:2] == 2'h0 && !RF_RDATA[0];
	endproperty
	a_fme_rd: assert property (p_fme_rd) else $error("stray bits at 00h");
	// a clear in the cpu slot must stop the very next group
	property p_fme_clr;
		$past(CPU_HOLD) && !CPU_HOLD && RF_WE && RF_ADDR == 7'h00 && !RF_WDATA[1]
			|=> !CPU_HOLD [*7];
	endproperty
	a_fme_clr: assert property (p_fme_clr) else $error("fetch went on after clear");
	property p_col;
		PIX_VALID |-> PIX_DATA[14:10] < 5'h13;
	endproperty
	a_col: assert property (p_col) else $error("column beyond grid");
	property p_stall;
		PIX_VALID && !PIX_READY |=> PIX_VALID && $stable(PIX_DATA);
	endproperty
	a_stall: assert property (p_stall) else $error("entry lost while stalled");
	c_group: cover property ($rose(CPU_HOLD));
	c_pop: cover property (PIX_VALID && PIX_READY);
	c_int: cover property (INT_TAKE);
endmodule // ocdd_props

bind ocdd_top ocdd_props u_props (
	.CLK(CLK),
	.RST(RST),
	.RF_WE(RF_WE),
	.RF_ADDR(RF_ADDR),
	.RF_WDATA(RF_WDATA),
	.RF_RDATA(RF_RDATA),
	.PC_ADDR(PC_ADDR),
	.PMEM_ADDR(PMEM_ADDR),
	.CPU_DBANK(CPU_DBANK),
	.CPU_DADDR(CPU_DADDR),
	.DMEM_BANK(DMEM_BANK),
	.DMEM_ADDR(DMEM_ADDR),
	.CPU_HOLD(CPU_HOLD),
	.INT_TAKE(INT_TAKE),
	.DISPLAY_ON(DISPLAY_ON),
	.PIX_VALID(PIX_VALID),
	.PIX_READY(PIX_READY),
	.PIX_DATA(PIX_DATA)
);

// ### test/ocdd_top_tb_top.sv
// self-checking bench for the display fetch unit
`timescale 1ns/1ps
module ocdd_top_tb_top;
	reg CLK, RST, RF_WE, INT_REQ, HSYNC_PULSE, VSYNC_N, PIX_READY;
	reg [6:0] RF_ADDR;
	reg [3:0] RF_WDATA;
	wire [3:0] RF_RDATA, DMEM_RDATA;
	wire [11:0] PMEM_ADDR;
	wire [15:0] PMEM_RDATA;
	wire [1:0] DMEM_BANK;
	wire [6:0] DMEM_ADDR;
	wire CPU_HOLD, INT_TAKE, DISPLAY_ON, PIX_VALID;
	wire [24:0] PIX_DATA;
	int fails = 0;
	int n_compared = 0;
	int k, n;
	// register rows: address, write data, value read back
	logic [14:0] rows [0:5] = '{{7'h00, 4'hF, 4'h2}, {7'h00, 4'h0, 4'h0},
		{7'h30, 4'h1, 4'h1}, {7'h30, 4'h0, 4'h0}, {7'h21, 4'hF, 4'h0}, {7'h31, 4'h0, 4'h0}};
	// entries of the first line: reset colour, then rgb 3 after the control word
	logic [24:0] ex [0:1] = '{{7'h00, 3'h7, 5'h00, 6'h05, 4'h0},
		{7'h00, 3'h3, 5'h01, 6'h0A, 4'h0}};
	ocdd_top DUT (.CLK(CLK), .RST(RST), .RF_WE(RF_WE), .RF_ADDR(RF_ADDR),
		.RF_WDATA(RF_WDATA), .RF_RDATA(RF_RDATA), .PC_ADDR(12'h5A5), .CPU_DBANK(2'h0),
		.CPU_DADDR(7'h00), .PMEM_ADDR(PMEM_ADDR), .PMEM_RDATA(PMEM_RDATA),
		.DMEM_BANK(DMEM_BANK), .DMEM_ADDR(DMEM_ADDR), .DMEM_RDATA(DMEM_RDATA),
		.CPU_HOLD(CPU_HOLD), .INT_REQ(INT_REQ), .INT_TAKE(INT_TAKE),
		.HSYNC_PULSE(HSYNC_PULSE), .VSYNC_N(VSYNC_N), .DISPLAY_ON(DISPLAY_ON),
		.PIX_VALID(PIX_VALID), .PIX_READY(PIX_READY), .PIX_DATA(PIX_DATA));
	ocdd_mem_model u_mem (.dmem_bank(DMEM_BANK), .dmem_addr(DMEM_ADDR),
		.dmem_rdata(DMEM_RDATA), .pmem_addr(PMEM_ADDR), .pmem_rdata(PMEM_RDATA));
	always #25 CLK = ~CLK;
	task chk(input logic [24:0] s, input logic [24:0] e);
		n_compared++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task end_of_test;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// one write cycle, entered and left at a falling edge
	task rf_wr(input logic [6:0] a, input logic [3:0] d);
		RF_ADDR = a;
		RF_WDATA = d;
		RF_WE = 1;
		@(negedge CLK);
		RF_WE = 0;
	endtask
	// bounded wait on the hold line; a hang ends the run as a failure
	task wait_hold(input logic v);
		n = 0;
		while (CPU_HOLD !== v && n < 200) begin
			@(negedge CLK);
			n++;
		end
		if (CPU_HOLD !== v) begin
			fails++;
			end_of_test;
		end
	endtask
	initial begin
		CLK = 0;
		RST = 1;
		RF_WE = 0;
		RF_ADDR = 7'h00;
		RF_WDATA = 4'h0;
		INT_REQ = 1;
		HSYNC_PULSE = 0;
		VSYNC_N = 1;
		PIX_READY = 0;
		repeat (16) @(negedge CLK);
		RST = 0;
		chk(RF_RDATA, 4'h0);
		chk({CPU_HOLD, PIX_VALID, DISPLAY_ON}, 3'h0);
		foreach (rows[i]) begin
			rf_wr(rows[i][14:8], rows[i][7:4]);
			@(negedge CLK);
			chk(RF_RDATA, rows[i][3:0]);
		end
		// fetch first, display on in flyback, then fetch cleared: nothing may be stolen
		VSYNC_N = 0;
		rf_wr(7'h00, 4'h2);
		@(negedge CLK);
		rf_wr(7'h31, 4'h1);
		@(negedge CLK);
		rf_wr(7'h00, 4'h0);
		VSYNC_N = 1;
		repeat (8) begin
			@(negedge CLK);
			chk(CPU_HOLD, 1'b0);
		end
		rf_wr(7'h00, 4'h2);
		wait_hold(1);
		k = 0;
		while (CPU_HOLD === 1'b1 && k < 9) begin
			@(negedge CLK);
			k++;
		end
		chk(k, 5);
		chk(INT_TAKE, 1'b0);
		@(negedge CLK);
		chk(CPU_HOLD, 1'b1);
		// the return word must park fetching until the next line
		repeat (30) @(negedge CLK);
		repeat (8) begin
			@(negedge CLK);
			chk(CPU_HOLD, 1'b0);
		end
		chk(PIX_VALID, 1'b1);
		PIX_READY = 1;
		foreach (ex[i]) begin
			chk(PIX_DATA, ex[i]);
			@(negedge CLK);
		end
		chk(PIX_VALID, 1'b0);
		PIX_READY = 0;
		HSYNC_PULSE = 1;
		@(negedge CLK);
		HSYNC_PULSE = 0;
		wait_hold(1);
		wait_hold(0);
		rf_wr(7'h00, 4'h0);
		repeat (10) begin
			chk(CPU_HOLD, 1'b0);
			@(negedge CLK);
		end
		chk(INT_TAKE, 1'b1);
		chk(PIX_DATA[14:0], {5'h00, 6'h05, 4'h1});
		rf_wr(7'h31, 4'h0);
		chk(DISPLAY_ON, 1'b0);
		end_of_test;
	end
endmodule // ocdd_top_tb_top
